// *** rtl/pfd_pkg.sv ***
package pfd_pkg;
    localparam int FREQ_W = 16;
    localparam int TIME_W = 16;
    localparam int MODE_W = 8;
    localparam logic [MODE_W-1:0] MODE_COAST = 8'h00;
    localparam logic [MODE_W-1:0] MODE_STOP = 8'h01;
    localparam logic [MODE_W-1:0] MODE_REACC = 8'h02;
    localparam logic [MODE_W-1:0] MODE_AUTO_STOP = 8'h15;
    localparam logic [MODE_W-1:0] MODE_AUTO_REACC = 8'h16;
    localparam logic [TIME_W-1:0] SETTING_OFF = 16'h270F;
    localparam logic [FREQ_W-1:0] FREQ_OFF = 16'h270F;
    localparam logic [7:0] REGEN_EXTERNAL = 8'h02;
    localparam logic [7:0] TERM_POS = 8'h2E;
    localparam logic [7:0] TERM_NEG = 8'h92;
    localparam logic [FREQ_W-1:0] FREQ_ZERO = 16'h0000;
    // edges the run synchronisers need before their level is real
    localparam logic [1:0] SYNC_SETTLE = 2'h2;
    // one time unit is 0.1 s; freq step every accumulated overflow
    localparam int TIME_UNIT_NS = 100000000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int UNIT_CYCLES = TIME_UNIT_NS / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN = 3'b001,
        ST_DECEL = 3'b010,
        ST_STOPPED = 3'b011,
        ST_REACC = 3'b100,
        ST_RESTART = 3'b101,
        ST_COAST = 3'b110
    } pfd_state_type;
endpackage

// *** rtl/pfd_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module pfd_control
    import pfd_pkg::*;
#(
    parameter int UNIT_CYC = UNIT_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic undervoltagePin,
    input wire logic forward_run_cmd,
    input wire logic reverse_run_cmd,
    input wire logic tripActive,
    input wire logic [MODE_W-1:0] power_fail_stop_select,
    input wire logic [FREQ_W-1:0] fail_freq_subtract,
    input wire logic [FREQ_W-1:0] subtract_start_freq,
    input wire logic [TIME_W-1:0] fail_decel_time_first,
    input wire logic [TIME_W-1:0] fail_decel_time_second,
    input wire logic [FREQ_W-1:0] decel_slope_switch_freq,
    input wire logic [FREQ_W-1:0] ramp_reference_freq,
    input wire logic [TIME_W-1:0] restart_coast_time,
    input wire logic [7:0] regen_function_select,
    input wire logic [7:0] output_terminal_assign,
    input wire logic [FREQ_W-1:0] setFreq,
    input wire logic busVoltageHigh,
    output logic [FREQ_W-1:0] outFreq,
    output logic outputEnable,
    output logic dcBrake,
    output logic startAllowed,
    output logic stopSelectIgnore,
    output logic supplyTripSuppress,
    output logic restartRequest,
    output logic fail_decel_active_out,
    output logic fail_decel_status
);
    typedef struct packed {
        logic [1:0] uvSync;
        logic [1:0] fwdSync;
        logic [1:0] revSync;
        pfd_state_type state;
        logic [FREQ_W-1:0] freq;
        logic [31:0] acc;
        logic runPrev;
        logic blocked;
        logic brake;
        logic powerUp;
        logic [1:0] settle;
        logic [FREQ_W-1:0] outFreq;
        logic outEn;
        logic dcBrake;
        logic startOk;
        logic stopIgn;
        logic tripSup;
        logic restartReq;
        logic termOut;
        logic status;
    } pfd_regs_type;

    pfd_regs_type q_r;
    pfd_regs_type q_nxt;

    logic uv;
    logic run;
    logic fnOn;
    logic autoMode;
    logic reaccMode;
    logic [FREQ_W:0] stepDiff;
    logic [FREQ_W-1:0] startPoint;
    logic [TIME_W-1:0] slopeTime;
    logic [31:0] slopeLimit;
    logic [63:0] slopeWide;
    logic statusNxt;

    assign uv = q_r.uvSync[1];
    assign run = q_r.fwdSync[1] | q_r.revSync[1];
    assign fnOn = (power_fail_stop_select != MODE_COAST)
        && (restart_coast_time == SETTING_OFF)
        && (regen_function_select != REGEN_EXTERNAL);
    assign autoMode = (power_fail_stop_select == MODE_AUTO_STOP)
        || (power_fail_stop_select == MODE_AUTO_REACC);
    assign reaccMode = (power_fail_stop_select == MODE_REACC)
        || (power_fail_stop_select == MODE_AUTO_REACC);

    always_comb begin
        stepDiff = {1'b0, q_r.freq} - {1'b0, fail_freq_subtract};
        if (subtract_start_freq == FREQ_OFF
            || q_r.freq >= subtract_start_freq) begin
            startPoint = stepDiff[FREQ_W] ? FREQ_ZERO
                : stepDiff[FREQ_W-1:0];
        end else begin
            startPoint = q_r.freq;
        end
        if (q_r.freq < decel_slope_switch_freq
            && fail_decel_time_second != SETTING_OFF) begin
            slopeTime = fail_decel_time_second;
        end else begin
            slopeTime = fail_decel_time_first;
        end
    end

    always_comb begin
        slopeWide = (64'(slopeTime) * 64'(UNIT_CYC))
            / ((ramp_reference_freq == FREQ_ZERO) ? 64'h1
            : 64'(ramp_reference_freq));
        // long times saturate rather than wrap to a fast slope
        slopeLimit = (slopeWide[63:32] != 32'h0) ? 32'hFFFFFFFF
            : slopeWide[31:0];
    end

    always_comb begin
        q_nxt = q_r;
        q_nxt.uvSync = {q_r.uvSync[0], undervoltagePin};
        q_nxt.fwdSync = {q_r.fwdSync[0], forward_run_cmd};
        q_nxt.revSync = {q_r.revSync[0], reverse_run_cmd};
        q_nxt.runPrev = run;
        q_nxt.restartReq = 1'b0;
        // sync chain needs two edges before the run level is real
        if (q_r.powerUp) begin
            q_nxt.settle = q_r.settle + 2'h1;
            q_nxt.powerUp = (q_r.settle != SYNC_SETTLE);
        end
        if (q_r.powerUp && q_r.settle == SYNC_SETTLE && run && fnOn) begin
            q_nxt.blocked = 1'b1;
        end else if (!run) begin
            q_nxt.blocked = 1'b0;
        end
        case (q_r.state)
            ST_IDLE: begin
                q_nxt.freq = FREQ_ZERO;
                q_nxt.brake = 1'b0;
                if (run && !q_r.runPrev && !q_r.blocked && !uv
                    && !tripActive && !q_r.powerUp) begin
                    q_nxt.state = ST_RUN;
                end
            end
            ST_RUN: begin
                q_nxt.acc = 32'h0;
                if (tripActive) begin
                    q_nxt.state = ST_IDLE;
                end else if (uv && !fnOn) begin
                    q_nxt.state = ST_COAST;
                end else if (uv && autoMode) begin
                    q_nxt.state = ST_DECEL;
                end else if (uv) begin
                    q_nxt.freq = startPoint;
                    q_nxt.brake = stepDiff[FREQ_W];
                    q_nxt.state = stepDiff[FREQ_W]
                        ? ST_STOPPED : ST_DECEL;
                end else if (!run) begin
                    q_nxt.state = ST_IDLE;
                end else if (q_r.freq < setFreq) begin
                    q_nxt.freq = q_r.freq + 16'h0001;
                end else begin
                    q_nxt.freq = setFreq;
                end
            end
            ST_DECEL: begin
                if (autoMode) begin
                    if (!busVoltageHigh && q_r.freq != FREQ_ZERO) begin
                        q_nxt.freq = q_r.freq - 16'h0001;
                    end
                end else if (q_r.acc + 32'h1 >= slopeLimit) begin
                    q_nxt.acc = 32'h0;
                    if (q_r.freq != FREQ_ZERO) begin
                        q_nxt.freq = q_r.freq - 16'h0001;
                    end
                end else begin
                    q_nxt.acc = q_r.acc + 32'h1;
                end
                if (!uv && reaccMode) begin
                    q_nxt.state = ST_REACC;
                end else if (q_r.freq == FREQ_ZERO) begin
                    q_nxt.state = ST_STOPPED;
                    q_nxt.blocked = 1'b1;
                end
            end
            ST_REACC: begin
                if (uv) begin
                    q_nxt.state = ST_DECEL;
                end else begin
                    q_nxt.state = ST_RUN;
                end
            end
            ST_STOPPED: begin
                q_nxt.blocked = 1'b1;
                if (!uv && reaccMode
                    && restart_coast_time != SETTING_OFF) begin
                    q_nxt.state = ST_RESTART;
                end else if (!uv && !run) begin
                    q_nxt.state = ST_IDLE;
                    q_nxt.brake = 1'b0;
                    q_nxt.blocked = 1'b0;
                end
            end
            ST_RESTART: begin
                q_nxt.restartReq = 1'b1;
                q_nxt.blocked = 1'b0;
                q_nxt.state = ST_RUN;
            end
            ST_COAST: begin
                q_nxt.freq = FREQ_ZERO;
                if (!uv && !run) begin
                    q_nxt.state = ST_IDLE;
                end
            end
            default: begin
                q_nxt.state = ST_IDLE;
            end
        endcase
        statusNxt = uv || (q_nxt.state == ST_DECEL)
            || (q_nxt.state == ST_STOPPED);
        q_nxt.status = statusNxt;
        if (output_terminal_assign == TERM_POS) begin
            q_nxt.termOut = statusNxt;
        end else if (output_terminal_assign == TERM_NEG) begin
            q_nxt.termOut = !statusNxt;
        end else begin
            q_nxt.termOut = 1'b0;
        end
        q_nxt.outFreq = q_nxt.freq;
        q_nxt.outEn = (q_nxt.state != ST_IDLE)
            && (q_nxt.state != ST_COAST);
        q_nxt.dcBrake = q_nxt.brake;
        q_nxt.startOk = !q_nxt.blocked;
        q_nxt.stopIgn = (q_nxt.state == ST_DECEL);
        q_nxt.tripSup = fnOn;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q_r <= '0;
            q_r.state <= ST_IDLE;
            q_r.powerUp <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign outFreq = q_r.outFreq;
    assign outputEnable = q_r.outEn;
    assign dcBrake = q_r.dcBrake;
    assign startAllowed = q_r.startOk;
    assign stopSelectIgnore = q_r.stopIgn;
    assign supplyTripSuppress = q_r.tripSup;
    assign restartRequest = q_r.restartReq;
    assign fail_decel_active_out = q_r.termOut;
    assign fail_decel_status = q_r.status;

    a_status_on_uv: assert property (@(posedge clock) disable iff (rst)
        q_r.uvSync[1] |=> fail_decel_status)
        else $error("status low under undervoltage");

    a_term_invert: assert property (@(posedge clock) disable iff (rst)
        output_terminal_assign == TERM_NEG && $stable(output_terminal_assign)
        |-> fail_decel_active_out != fail_decel_status)
        else $error("inverted terminal not inverse");

    a_trip_suppress: assert property (@(posedge clock) disable iff (rst)
        regen_function_select == REGEN_EXTERNAL |=> !supplyTripSuppress)
        else $error("suppress with external converter");

    a_coast_mode: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_RUN && uv && !fnOn && !tripActive
        |=> ##1 !outputEnable)
        else $error("no coast in off mode");

    a_reacc_return: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_DECEL && !uv && reaccMode
        |=> q_r.state == ST_REACC ##1 q_r.state == ST_RUN)
        else $error("no reaccel on return");

    a_stop_holds: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_STOPPED && !reaccMode && run
        |=> q_r.blocked)
        else $error("block lost after stop");

    a_trip_skip: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_RUN && tripActive |=> q_r.state == ST_IDLE)
        else $error("failure stop while tripped");

    a_clamp_brake: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_RUN && uv && fnOn && !autoMode && !tripActive
        && stepDiff[FREQ_W] && (subtract_start_freq == FREQ_OFF)
        |=> dcBrake && outFreq == FREQ_ZERO)
        else $error("no clamp and brake");

    a_powerup_block: assert property (@(posedge clock) disable iff (rst)
        q_r.powerUp && q_r.settle == SYNC_SETTLE && run && fnOn
        |=> !startAllowed)
        else $error("run at power-up not refused");

    a_powerup_idle: assert property (@(posedge clock) disable iff (rst)
        q_r.powerUp |=> q_r.state == ST_IDLE)
        else $error("start during power-up settle");

    a_step_fail: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_RUN && uv && fnOn && !autoMode && !tripActive
        |=> outFreq == $past(startPoint))
        else $error("no frequency step on failure");

    a_auto_enter: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_RUN && uv && fnOn && autoMode && !tripActive
        |=> q_r.state == ST_DECEL)
        else $error("auto mode did not ramp");

    a_auto_hold: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_DECEL && autoMode && busVoltageHigh
        |=> q_r.freq == $past(q_r.freq))
        else $error("auto ramp ignored high bus");

    a_slope_wait: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_DECEL && !autoMode && q_r.acc + 32'h1 < slopeLimit
        |=> q_r.freq == $past(q_r.freq))
        else $error("ramp stepped too early");

    a_status_ramp: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_DECEL || q_r.state == ST_STOPPED
        |-> fail_decel_status)
        else $error("status low in ramp or stop");

    a_stop_ignore: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_DECEL |-> stopSelectIgnore)
        else $error("stop selection not ignored");

    a_coast_off: assert property (@(posedge clock) disable iff (rst)
        restart_coast_time != SETTING_OFF |=> !supplyTripSuppress)
        else $error("function on with restart set");

    a_trip_sup_on: assert property (@(posedge clock) disable iff (rst)
        fnOn |=> supplyTripSuppress)
        else $error("supply trips not suppressed");

    a_term_pos: assert property (@(posedge clock) disable iff (rst)
        output_terminal_assign == TERM_POS && $stable(output_terminal_assign)
        |-> fail_decel_active_out == fail_decel_status)
        else $error("positive terminal not status");

    a_block_idle: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_IDLE && q_r.blocked |=> q_r.state == ST_IDLE)
        else $error("blocked drive started");

    a_restart_pulse: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_RESTART |=> restartRequest)
        else $error("no restart request");

    a_coast_freq: assert property (@(posedge clock) disable iff (rst)
        q_r.state == ST_COAST |=> outFreq == FREQ_ZERO)
        else $error("frequency kept while coasting");
endmodule
`default_nettype wire

// *** sim/pfd_supply_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pfd_supply_model (
    input wire logic clock,
    input wire logic failCmd,
    input wire logic regenStrong,
    output logic undervoltagePin,
    output logic busVoltageHigh
);
    logic phase;
    initial begin
        undervoltagePin = 1'b0;
        busVoltageHigh = 1'b0;
        phase = 1'b0;
    end
    // a strong load pumps the bus only every other cycle, so slow ramps
    // posedge update avoids a race with the bench's negedge stimulus
    always @(posedge clock) begin
        phase <= ~phase;
        undervoltagePin <= failCmd;
        busVoltageHigh <= failCmd & regenStrong & phase;
    end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pfd_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic failCmd = 1'b0;
    logic regenStrong = 1'b0;
    logic uvPin, busHigh, fwdRun = 1'b0, tripIn = 1'b0;
    logic [MODE_W-1:0] mode = MODE_STOP;
    logic [FREQ_W-1:0] subF, startF, switchF, refF, setF;
    logic [TIME_W-1:0] firstT, secondT, coastT;
    logic [7:0] regenSel, termSel;
    logic [FREQ_W-1:0] outFreq;
    logic outEn, dcBrake, startOk, stopIgn, tripSup, restartReq;
    logic activeOut, status;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    always #5 clock = ~clock;
    pfd_supply_model pfd_supply_model_inst (.clock(clock),
        .failCmd(failCmd), .regenStrong(regenStrong),
        .undervoltagePin(uvPin), .busVoltageHigh(busHigh));
    pfd_control #(.UNIT_CYC(2)) pfd_control_inst (.clock(clock), .rst(rst),
        .undervoltagePin(uvPin), .forward_run_cmd(fwdRun),
        .reverse_run_cmd(1'b0), .tripActive(tripIn),
        .power_fail_stop_select(mode), .fail_freq_subtract(subF),
        .subtract_start_freq(startF), .fail_decel_time_first(firstT),
        .fail_decel_time_second(secondT),
        .decel_slope_switch_freq(switchF), .ramp_reference_freq(refF),
        .restart_coast_time(coastT), .regen_function_select(regenSel),
        .output_terminal_assign(termSel), .setFreq(setF),
        .busVoltageHigh(busHigh), .outFreq(outFreq), .outputEnable(outEn),
        .dcBrake(dcBrake), .startAllowed(startOk), .stopSelectIgnore(stopIgn),
        .supplyTripSuppress(tripSup), .restartRequest(restartReq),
        .fail_decel_active_out(activeOut), .fail_decel_status(status));
    task automatic wrap_up();
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            wrap_up();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // 30 s over 60 Hz with UNIT_CYC 2 gives 10 cycles per hertz
    task automatic load(input logic [MODE_W-1:0] m, input logic [15:0] f);
        mode = m;
        setF = f;
        subF = 16'h0003;
        startF = FREQ_OFF;
        switchF = 16'h000A;
        refF = 16'h003C;
        firstT = 16'h012C;
        secondT = SETTING_OFF;
        coastT = SETTING_OFF;
        regenSel = 8'h00;
        termSel = TERM_POS;
    endtask
    task automatic setup(input logic [MODE_W-1:0] m, input logic [15:0] f);
        @(negedge clock);
        rst = 1'b1;
        fwdRun = 1'b0;
        failCmd = 1'b0;
        regenStrong = 1'b0;
        tripIn = 1'b0;
        load(m, f);
        cyc(3);
        rst = 1'b0;
        cyc(4);
    endtask
    task automatic wait_freq(input logic [15:0] v, input int lim);
        for (int i = 0; i < lim && outFreq !== v; i++) cyc(1);
        check(outFreq, v);
    endtask
    task automatic start_run();
        fwdRun = 1'b1;
        cyc(1);
        wait_freq(setF, setF + 20);
    endtask
    task automatic fail_now();
        failCmd = 1'b1;
        for (int i = 0; i < 20 && status !== 1'b1; i++) cyc(1);
        cyc(1);
    endtask
    initial begin
        load(MODE_STOP, 16'h0028);
        fwdRun = 1'b1;
        cyc(3);
        rst = 1'b0;
        cyc(20);
        // run held through power-up stays refused
        check(outFreq, 16'h0000);
        check(startOk, 1'b0);
        setup(MODE_STOP, 16'h0028);
        secondT = 16'h001E;
        start_run();
        fail_now();
        check(outFreq, 16'h0025);
        check(activeOut, 1'b1);
        check(tripSup, 1'b1);
        check(stopIgn, 1'b1);
        cyc(100);
        check(outFreq >= 16'h001A && outFreq <= 16'h001C, 1'b1);
        failCmd = 1'b0;
        wait_freq(16'h0009, 400);
        cyc(12);
        check(outFreq, 16'h0000);
        cyc(20);
        check(outFreq, 16'h0000);
        check(status, 1'b1);
        fwdRun = 1'b0;
        cyc(4);
        start_run();
        setup(MODE_REACC, 16'h000C);
        start_run();
        fail_now();
        check(outFreq, 16'h0009);
        cyc(20);
        check(outFreq >= 16'h0006 && outFreq <= 16'h0008, 1'b1);
        failCmd = 1'b0;
        wait_freq(16'h000C, 40);
        setup(MODE_STOP, 16'h0014);
        startF = 16'h001E;
        start_run();
        fail_now();
        check(outFreq, 16'h0014);
        setup(MODE_STOP, 16'h0002);
        start_run();
        fail_now();
        check(outFreq, 16'h0000);
        check(dcBrake, 1'b1);
        setup(MODE_COAST, 16'h0014);
        termSel = TERM_NEG;
        start_run();
        fail_now();
        cyc(4);
        check(outEn, 1'b0);
        check(status, 1'b1);
        check(activeOut, 1'b0);
        for (int k = 0; k < 2; k++) begin
            setup(MODE_STOP, 16'h0014);
            coastT = (k == 0) ? 16'h0064 : SETTING_OFF;
            regenSel = (k == 0) ? 8'h00 : REGEN_EXTERNAL;
            start_run();
            failCmd = 1'b1;
            cyc(30);
            check(stopIgn, 1'b0);
        end
        for (int k = 0; k < 2; k++) begin
            setup(k == 0 ? MODE_AUTO_STOP : MODE_AUTO_REACC, 16'h0028);
            regenStrong = (k == 1);
            start_run();
            fail_now();
            wait_freq(16'h0000, 100);
        end
        setup(MODE_STOP, 16'h0014);
        start_run();
        tripIn = 1'b1;
        cyc(2);
        tripIn = 1'b0;
        failCmd = 1'b1;
        cyc(10);
        check(dcBrake, 1'b0);
        check(outEn, 1'b0);
        check(status, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
